// [rtl/wam_pkg.sv]
// Purpose: shared constants for the weld alarm monitor
// Assumes: 32-bit apb data, 16-bit measurement inputs except the 8-bit temperature
// Notes: settings are kept in an indexed bank, defaults below
package wam_pkg;
   // apb byte offsets of the fixed registers
   localparam logic [7:0] WAM_OFS_OVL = 8'h00;   // group 0 alarm word, write 1 to clear
   localparam logic [7:0] WAM_OFS_CUT = 8'h04;   // group 1 alarm word, write 1 to clear
   localparam logic [7:0] WAM_OFS_SET = 8'h08;   // group 2 alarm word, write 1 to clear
   localparam logic [7:0] WAM_OFS_STAT = 8'h0c;  // live status, read only
   localparam logic [7:0] WAM_OFS_VER = 8'h10;   // software version, read only
   localparam logic [7:0] WAM_OFS_CFG0 = 8'h20;  // first settings word, one word each after it
   localparam int WAM_NCFG = 13;                 // number of settings words
   // settings indices
   localparam int WAM_CFG_PH_LIM = 0;     // phase magnitude limit
   localparam int WAM_CFG_PH_TIME = 1;    // phase limit time in clock cycles
   localparam int WAM_CFG_F_LO = 2;       // overload frequency window, low edge
   localparam int WAM_CFG_F_HI = 3;       // overload frequency window, high edge
   localparam int WAM_CFG_E_CUT = 4;      // energy cutoff
   localparam int WAM_CFG_P_CUT = 5;      // peak power cutoff
   localparam int WAM_CFG_A1_CUT = 6;     // custom input one cutoff
   localparam int WAM_CFG_A2_CUT = 7;     // custom input two cutoff
   localparam int WAM_CFG_T_CUT = 8;      // sonics-on time cutoff in cycles
   localparam int WAM_CFG_F_LOFS = 9;     // low offset below start frequency
   localparam int WAM_CFG_F_HOFS = 10;    // high offset above start frequency
   localparam int WAM_CFG_AMPL = 11;      // stored amplitude setting
   localparam int WAM_CFG_NET = 12;       // network address
   // factory defaults, index 0 in the lowest word
   localparam logic [WAM_NCFG-1:0][31:0] WAM_CFG_DEF = {
      32'h0a00_0001, 32'h0000_0064, 32'h0000_0064, 32'h0000_0064, 32'h0000_2000,
      32'h0000_0800, 32'h0000_0800, 32'h0000_0400, 32'h0010_0000, 32'h0000_4eb8,
      32'h0000_4c2c, 32'h0000_0010, 32'h0000_0100};
   // alarm bit positions
   localparam int WAM_B_PHASE = 1;        // phase, within group 0
   localparam int WAM_B_CURR = 2;
   localparam int WAM_B_FREQ = 3;
   localparam int WAM_B_POWER = 4;
   localparam int WAM_B_VOLT = 5;
   localparam int WAM_B_TEMP = 6;
   localparam int WAM_B_BRAKE0 = 17;      // braking phase overload, next four follow
   localparam int WAM_B_ECUT = 2;         // group 1
   localparam int WAM_B_PCUT = 3;
   localparam int WAM_B_A1CUT = 4;
   localparam int WAM_B_TCUT = 5;
   localparam int WAM_B_FLCUT = 6;
   localparam int WAM_B_FHCUT = 7;
   localparam int WAM_B_A2CUT = 8;
   localparam int WAM_B_PRESET = 2;       // group 2
   // system limits, fixed by the power stage
   localparam logic [15:0] WAM_PEAK_CURR = 16'hf000;
   localparam logic [15:0] WAM_PEAK_POWER = 16'hf000;
   localparam logic [15:0] WAM_PEAK_VOLT = 16'hf000;
   localparam logic [7:0] WAM_TEMP_TRIP = 8'h55;   // 85 degrees c, sensor tolerance 5 degrees
   localparam logic [7:0] WAM_PRESET_MAX = 8'h20;  // highest valid preset number, 32
   localparam logic [31:0] WAM_SW_VER = 32'h0001_0203;  // arbitrary value
   // power-up sequencer states
   typedef enum logic [2:0] {
      WAM_PU_SAMPLE = 3'b001,
      WAM_PU_COLD = 3'b010,
      WAM_PU_RUN = 3'b100
   } wam_pu_t;
endpackage

// [rtl/wam_top.sv]
// Purpose: alarm monitor for an ultrasonic weld generator, apb register slave
// Assumes: one 200 MHz clock, synchronous active-low reset, inputs synchronous
// Notes: groups 0 to 2 only; no wait states on any apb access
//
// Behaviour
// - overload: stop sonics, then abort cycle
// - phase out of limit for time: bit 1
// - current at peak limit: bit 2
// - frequency outside low/high window: bit 3
// - power at peak limit: bit 4
// - voltage at peak limit: bit 5
// - heat sink at 85 degrees: bit 6
// - temperature alarm clears only below threshold
// - braking overloads on bits 17 to 21
// - cutoff stops sonics, cycle continues
// - sonics-on energy over cutoff: bit 2
// - sonics-on peak power over cutoff: bit 3
// - custom inputs over cutoff: bits 4, 8
// - sonics-on time over cutoff: bit 5
// - frequency below start minus offset: bit 6
// - frequency above start plus offset: bit 7
// - preset number above 32: setup bit 2
// - cold start reloads factory defaults
// - amplitude, address, settings overwritten
// - software version survives cold start
// - strap sampled at power-up triggers cold start
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module wam_top
   import wam_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_weld_on,
   input wire logic i_brake_on,
   input wire logic i_sonics_on,
   input wire logic [15:0] i_phase,
   input wire logic [15:0] i_current,
   input wire logic [15:0] i_freq,
   input wire logic [15:0] i_power,
   input wire logic [15:0] i_voltage,
   input wire logic [7:0] i_temp,
   input wire logic [15:0] i_ain1,
   input wire logic [15:0] i_ain2,
   input wire logic i_preset_req,
   input wire logic [7:0] i_preset_num,
   input wire logic i_cold_strap,
   output logic o_sonics_stop,
   output logic o_cycle_abort,
   output logic o_cold_done
);
   // settings bank and alarm words
   logic [31:0] cfg_r [WAM_NCFG];    // user settings, restored by cold start
   logic [31:0] ovl_r;               // group 0 word
   logic [31:0] cut_r;               // group 1 word
   logic [31:0] set_r;               // group 2 word
   wam_pu_t pu_r;                    // power-up sequencer
   logic weld_d_r;                   // weld flag one cycle ago
   logic [15:0] f_start_r;           // frequency captured at weld start
   logic [31:0] ph_cnt_r;            // consecutive out-of-limit phase cycles
   logic [31:0] energy_r;            // energy summed while sonics on
   logic [31:0] son_time_r;          // sonics-on cycles in this weld
   logic [15:0] peak_p_r;            // peak power while sonics on
   logic ovl_pend_r;                 // overload seen, abort follows
   logic stop_r;
   logic abort_r;
   logic cold_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;

   // apb decode
   wire setup_ph = i_psel & ~i_penable;
   wire wr_en = i_psel & i_penable & pready_r & i_pwrite;
   wire [7:0] cfg_ofs = i_paddr - WAM_OFS_CFG0;
   wire cfg_hit = (i_paddr >= WAM_OFS_CFG0) && (cfg_ofs[7:2] < 6'(WAM_NCFG)) && (i_paddr[1:0] == 2'b00);
   wire [3:0] cfg_idx = cfg_ofs[5:2];
   wire fix_hit = (i_paddr == WAM_OFS_OVL) || (i_paddr == WAM_OFS_CUT) || (i_paddr == WAM_OFS_SET)
                  || (i_paddr == WAM_OFS_STAT) || (i_paddr == WAM_OFS_VER);
   wire addr_ok = cfg_hit | fix_hit;
   wire [31:0] status_w = {28'h0, cold_r, abort_r, stop_r, (pu_r == WAM_PU_RUN)};
   wire [31:0] rd_mux = (i_paddr == WAM_OFS_OVL) ? ovl_r :
                        (i_paddr == WAM_OFS_CUT) ? cut_r :
                        (i_paddr == WAM_OFS_SET) ? set_r :
                        (i_paddr == WAM_OFS_STAT) ? status_w :
                        (i_paddr == WAM_OFS_VER) ? WAM_SW_VER :
                        cfg_hit ? cfg_r[cfg_idx] : 32'h0;

   // measurement comparisons, evaluated every cycle
   wire active = i_weld_on | i_brake_on;
   wire ph_out = i_phase > cfg_r[WAM_CFG_PH_LIM][15:0];
   wire [31:0] ph_cnt_nxt = (active & ph_out) ? ph_cnt_r + 32'h1 : 32'h0;
   wire ph_hit = active & ph_out & (ph_cnt_nxt >= cfg_r[WAM_CFG_PH_TIME]);
   wire cur_hit = i_current >= WAM_PEAK_CURR;
   wire frq_hit = (i_freq < cfg_r[WAM_CFG_F_LO][15:0]) || (i_freq > cfg_r[WAM_CFG_F_HI][15:0]);
   wire pwr_hit = i_power >= WAM_PEAK_POWER;
   wire vlt_hit = i_voltage >= WAM_PEAK_VOLT;
   wire temp_hot = i_temp >= WAM_TEMP_TRIP;
   wire [4:0] ovl_vec = {vlt_hit, pwr_hit, frq_hit, cur_hit, ph_hit};
   // weld codes go low, braking codes to bits 17 and up
   wire [31:0] ovl_set = ({26'h0, ovl_vec & {5{i_weld_on}}, 1'b0})
                         | ({10'h0, ovl_vec & {5{i_brake_on}}, 17'h0})
                         | (32'(temp_hot) << WAM_B_TEMP);
   wire ovl_evt = |ovl_set;

   // cutoffs, only while welding
   wire weld_start = i_weld_on & ~weld_d_r;
   wire son_w = i_weld_on & i_sonics_on;
   wire [31:0] energy_nxt = weld_start ? 32'h0 : (son_w ? energy_r + {16'h0, i_power} : energy_r);
   wire [31:0] son_time_nxt = weld_start ? 32'h0 : (son_w ? son_time_r + 32'h1 : son_time_r);
   wire [15:0] peak_nxt = weld_start ? 16'h0 : ((son_w && i_power > peak_p_r) ? i_power : peak_p_r);
   wire [15:0] f_ref = weld_start ? i_freq : f_start_r;
   wire [16:0] f_lo_sum = {1'b0, i_freq} + {1'b0, cfg_r[WAM_CFG_F_LOFS][15:0]};
   wire [16:0] f_hi_sum = {1'b0, f_ref} + {1'b0, cfg_r[WAM_CFG_F_HOFS][15:0]};
   wire e_cut = son_w & (energy_nxt > cfg_r[WAM_CFG_E_CUT]);
   wire p_cut = son_w & ({16'h0, peak_nxt} > cfg_r[WAM_CFG_P_CUT]);
   wire a1_cut = i_weld_on & ({16'h0, i_ain1} > cfg_r[WAM_CFG_A1_CUT]);
   wire a2_cut = i_weld_on & ({16'h0, i_ain2} > cfg_r[WAM_CFG_A2_CUT]);
   wire t_cut = son_w & (son_time_nxt > cfg_r[WAM_CFG_T_CUT]);
   wire fl_cut = i_weld_on & (f_lo_sum < {1'b0, f_ref});
   wire fh_cut = i_weld_on & ({1'b0, i_freq} > f_hi_sum);
   wire [31:0] cut_set = {23'h0, a2_cut, fh_cut, fl_cut, t_cut, a1_cut, p_cut, e_cut, 2'b00};
   wire cut_evt = |cut_set;

   // setup alarm from preset recall
   wire [31:0] set_set = 32'(i_preset_req && (i_preset_num > WAM_PRESET_MAX)) << WAM_B_PRESET;

   // clear masks, set wins over clear; the hot bit refuses to clear
   wire wr_ovl = wr_en & (i_paddr == WAM_OFS_OVL);
   wire wr_cut = wr_en & (i_paddr == WAM_OFS_CUT);
   wire wr_set = wr_en & (i_paddr == WAM_OFS_SET);
   wire [31:0] ovl_clr = (wr_ovl ? i_pwdata : 32'h0) & ~(32'(temp_hot) << WAM_B_TEMP);
   wire [31:0] cut_clr = wr_cut ? i_pwdata : 32'h0;
   wire [31:0] set_clr = wr_set ? i_pwdata : 32'h0;
   wire cold_go = (pu_r == WAM_PU_COLD);

   // power-up sequencer: strap is looked at in the first cycle after release
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         pu_r <= WAM_PU_SAMPLE;
      else
      begin
         unique case (pu_r)
            WAM_PU_SAMPLE: pu_r <= i_cold_strap ? WAM_PU_COLD : WAM_PU_RUN;
            WAM_PU_COLD: pu_r <= WAM_PU_RUN;
            WAM_PU_RUN: pu_r <= WAM_PU_RUN;
            default: pu_r <= WAM_PU_SAMPLE;
         endcase
      end
   end

   // settings bank; cold start reloads every word, version is a constant and stays
   always_ff @(posedge i_ref_clk)
   begin
      for (int k = 0; k < WAM_NCFG; k++)
      begin
         if (!i_reset_n || cold_go)
            cfg_r[k] <= WAM_CFG_DEF[k];
         else if (wr_en && cfg_hit && (cfg_idx == 4'(k)))
            cfg_r[k] <= i_pwdata;
      end
   end

   // sticky alarm words
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n || cold_go)
      begin
         ovl_r <= 32'h0;
         cut_r <= 32'h0;
         set_r <= 32'h0;
      end
      else
      begin
         ovl_r <= (ovl_r & ~ovl_clr) | ovl_set;
         cut_r <= (cut_r & ~cut_clr) | cut_set;
         set_r <= (set_r & ~set_clr) | set_set;
      end
   end

   // per-weld trackers
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         weld_d_r <= 1'b0;
         f_start_r <= 16'h0;
         ph_cnt_r <= 32'h0;
         energy_r <= 32'h0;
         son_time_r <= 32'h0;
         peak_p_r <= 16'h0;
      end
      else
      begin
         weld_d_r <= i_weld_on;
         f_start_r <= f_ref;
         ph_cnt_r <= ph_cnt_nxt;
         energy_r <= energy_nxt;
         son_time_r <= son_time_nxt;
         peak_p_r <= peak_nxt;
      end
   end

   // sonics stop and abort: stop first, abort on the next edge, both held while active
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         ovl_pend_r <= 1'b0;
         stop_r <= 1'b0;
         abort_r <= 1'b0;
      end
      else
      begin
         ovl_pend_r <= ovl_evt & active;
         stop_r <= (active & stop_r) | ((ovl_evt | cut_evt) & active);
         abort_r <= active & (abort_r | ovl_pend_r);
      end
   end

   // cold start done flag, kept until the next reset
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
         cold_r <= 1'b0;
      else if (cold_go)
         cold_r <= 1'b1;
   end

   // apb answer: data captured in setup, pready high for the single access cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= setup_ph;
         pslverr_r <= setup_ph & ~addr_ok;
         if (setup_ph)
            prdata_r <= rd_mux;
      end
   end

   assign o_prdata = prdata_r;
   assign o_pready = pready_r;
   assign o_pslverr = pslverr_r;
   assign o_sonics_stop = stop_r;
   assign o_cycle_abort = abort_r;
   assign o_cold_done = cold_r;

   // checks
   sequence s_ovl_weld;
      i_weld_on && ovl_evt;
   endsequence
   sequence s_stop_abort;
      o_sonics_stop && !o_cycle_abort ##1 o_cycle_abort;
   endsequence

   chk_stop_then_abort: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (s_ovl_weld ##1 i_weld_on [*2]) |-> s_stop_abort or (o_cycle_abort ##1 o_cycle_abort))
      else $error("overload did not stop then abort");

   chk_cut_no_abort: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_weld_on && cut_evt && !ovl_evt && !o_cycle_abort && !ovl_pend_r) |=> o_sonics_stop && !o_cycle_abort)
      else $error("cutoff aborted or did not stop");

   chk_temp_hold: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n || cold_go)
      (ovl_r[WAM_B_TEMP] && temp_hot) |=> ovl_r[WAM_B_TEMP])
      else $error("hot alarm cleared while hot");

   chk_preset_bad: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n || cold_go)
      (i_preset_req && i_preset_num > 8'h20) |=> set_r[WAM_B_PRESET])
      else $error("invalid preset not flagged");

   chk_preset_good: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (!$past(set_r[WAM_B_PRESET]) && set_r[WAM_B_PRESET]) |-> $past(i_preset_req && i_preset_num > 8'h20))
      else $error("preset alarm without cause");

   chk_brake_curr: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n || cold_go)
      (i_brake_on && i_current >= WAM_PEAK_CURR) |=> ovl_r[WAM_B_BRAKE0 + 1])
      else $error("braking current overload missing");

   chk_phase_time: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      ph_hit |-> (ph_cnt_r + 32'h1 >= cfg_r[WAM_CFG_PH_TIME]) && ph_out)
      else $error("phase alarm before limit time");

   chk_cold_reload: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (pu_r == WAM_PU_COLD) |=> (cfg_r[WAM_CFG_AMPL] == WAM_CFG_DEF[WAM_CFG_AMPL]) && o_cold_done && ovl_r == 32'h0)
      else $error("cold start did not reload defaults");

   chk_strap_sample: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (pu_r == WAM_PU_SAMPLE) |=> (pu_r == WAM_PU_COLD) == $past(i_cold_strap))
      else $error("strap not sampled at power-up");

   chk_apb_ready: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      (i_psel && !i_penable) |=> o_pready ##1 !o_pready)
      else $error("apb ready not one cycle after setup");
endmodule

// [test/wam_stack_model.sv]
// Purpose: stand-in for the converter stack and the user io controller
// Assumes: the bench commands run and strap; stop comes from the monitor
// Notes: sonics fall one cycle after a stop request, as a real stack would
`timescale 1ns/1ps
module wam_stack_model
(
   input wire logic i_ref_clk,
   input wire logic i_run,
   input wire logic i_strap_fit,
   input wire logic i_stop,
   output logic o_sonics_on,
   output logic o_cold_strap
);
   // strap stays joined for as long as the bench keeps it fitted at power-up
   assign o_cold_strap = i_strap_fit;
   // output stage follows the run request unless the monitor says stop
   always_ff @(posedge i_ref_clk)
   begin
      o_sonics_on <= i_run & ~i_stop;
   end
endmodule

// [test/wam_top_test.sv]
// Purpose: self-checking bench for the weld alarm monitor
// Assumes: default settings after every reset, apb answers on its own time
// Notes: long counts run at full length, the time cutoff takes most cycles
`timescale 1ns/1ps
module wam_top_test import wam_pkg::*;;
   localparam logic [7:0] A_AMPL = WAM_OFS_CFG0 + 8'(4 * WAM_CFG_AMPL); // amplitude word
   localparam logic [7:0] A_NET = WAM_OFS_CFG0 + 8'(4 * WAM_CFG_NET);   // network address word
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0, pen = 1'h0, pwr = 1'h0, preq = 1'h0;
   logic weld = 1'h0, brake = 1'h0, run = 1'h0, strap = 1'h0;
   logic [7:0] paddr = 8'h00, temp = 8'h19, pnum = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, err, sonics, cstrap, stop, abort, cold_done;
   logic [15:0] phase = 16'h0, cur = 16'h0, freq = 16'h4d00, power = 16'h0, volt = 16'h0;
   logic [15:0] ain1 = 16'h0, ain2 = 16'h0;
   int miscompares = 0, total_checks = 0, cycles = 0;
   always #2.5 clk = ~clk;
   wam_top dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_weld_on(weld), .i_brake_on(brake), .i_sonics_on(sonics), .i_phase(phase), .i_current(cur),
      .i_freq(freq), .i_power(power), .i_voltage(volt), .i_temp(temp), .i_ain1(ain1), .i_ain2(ain2),
      .i_preset_req(preq), .i_preset_num(pnum), .i_cold_strap(cstrap), .o_sonics_stop(stop),
      .o_cycle_abort(abort), .o_cold_done(cold_done));
   wam_stack_model stack (.i_ref_clk(clk), .i_run(run), .i_strap_fit(strap), .i_stop(stop),
      .o_sonics_on(sonics), .o_cold_strap(cstrap));
   // hang guard: the whole run needs about 9600 cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares = miscompares + 1;
         stop_test();
      end
   end
   task stop_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready is seen high at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1 && n < 16)
      begin
         @(posedge clk);
         n++;
      end
      chk("pready", 32'h1, {31'h0, pready});
      q = prdata;
      err = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
      // one idle edge, so a following transfer never drives psel twice in one step
      @(posedge clk);
   endtask
   task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(nm, e, q);
   endtask
   // reset for six cycles with the strap fitted or not
   task do_reset(input logic s);
      rst_n <= 1'h0;
      strap <= s;
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      repeat (4) @(posedge clk);
   endtask
   // active phase of n cycles, weld in bit 0 and braking in bit 1
   task act(input logic [1:0] wb, input int n);
      weld <= wb[0];
      brake <= wb[1];
      run <= 1'h1;
      repeat (n) @(posedge clk);
      weld <= 1'h0;
      brake <= 1'h0;
      run <= 1'h0;
      @(posedge clk);
   endtask
   // read one alarm word, then clear it so the next case starts clean
   task hit(input logic [7:0] a, input logic [31:0] e, input logic [1:0] wb, input int n);
      act(wb, n);
      rd("alarm word", a, e);
      apb(1'h1, a, 32'hffff_ffff);
   endtask
   task t_cold();
      chk("cold done", 32'h0, {31'h0, cold_done});
      apb(1'h1, A_AMPL, 32'h55);
      rd("amplitude", A_AMPL, 32'h55);
      apb(1'h1, WAM_OFS_VER, 32'h0);
      do_reset(1'h1);
      chk("cold done", 32'h1, {31'h0, cold_done});
      rd("amplitude", A_AMPL, WAM_CFG_DEF[WAM_CFG_AMPL]);
      rd("net address", A_NET, WAM_CFG_DEF[WAM_CFG_NET]);
      rd("version", WAM_OFS_VER, WAM_SW_VER);
      apb(1'h0, 8'h14, 32'h0);
      chk("slave error", 32'h1, {31'h0, err});
      $display("test cold start done");
   endtask
   task t_overload();
      weld <= 1'h1;
      run <= 1'h1;
      cur <= 16'hf000;
      @(posedge clk);
      #1 chk("stop", 32'h1, {31'h0, stop});
      chk("abort", 32'h0, {31'h0, abort});
      @(posedge clk);
      #1 chk("abort", 32'h1, {31'h0, abort});
      @(posedge clk);
      cur <= 16'h0;
      act(2'b00, 1);
      #1 chk("stop and abort", 32'h0, {30'h0, stop, abort});
      @(posedge clk);
      rd("overload", WAM_OFS_OVL, 32'h1 << WAM_B_CURR);
      rd("overload", WAM_OFS_OVL, 32'h1 << WAM_B_CURR);
      apb(1'h1, WAM_OFS_OVL, 32'h1 << WAM_B_CURR);
      rd("overload", WAM_OFS_OVL, 32'h0);
      phase <= 16'h0101;
      hit(WAM_OFS_OVL, 32'h0, 2'b01, int'(WAM_CFG_DEF[WAM_CFG_PH_TIME]) - 1);
      hit(WAM_OFS_OVL, 32'h1 << WAM_B_PHASE, 2'b01, int'(WAM_CFG_DEF[WAM_CFG_PH_TIME]));
      phase <= 16'h0;
      freq <= 16'h4c2b;
      hit(WAM_OFS_OVL, 32'h1 << WAM_B_FREQ, 2'b01, 3);
      freq <= 16'h4d00;
      power <= 16'hf000;
      hit(WAM_OFS_OVL, 32'h1 << WAM_B_POWER, 2'b01, 3);
      hit(WAM_OFS_OVL, 32'h1 << (WAM_B_BRAKE0 + 3), 2'b10, 3);
      power <= 16'h0;
      volt <= 16'hf000;
      hit(WAM_OFS_OVL, 32'h1 << WAM_B_VOLT, 2'b01, 3);
      hit(WAM_OFS_OVL, 32'h1 << (WAM_B_BRAKE0 + 4), 2'b10, 3);
      volt <= 16'h0;
      cur <= 16'hf000;
      hit(WAM_OFS_OVL, 32'h1 << (WAM_B_BRAKE0 + 1), 2'b10, 3);
      cur <= 16'h0;
      $display("test overload done");
   endtask
   // frequency moves away from its start value in mid weld
   task fcut(input logic [15:0] f, input logic [31:0] e);
      weld <= 1'h1;
      run <= 1'h1;
      repeat (2) @(posedge clk);
      freq <= f;
      repeat (2) @(posedge clk);
      freq <= 16'h4d00;
      hit(WAM_OFS_CUT, e, 2'b00, 1);
   endtask
   task t_cutoff();
      // the power overload welds also tripped the peak power cutoff, start clean
      apb(1'h1, WAM_OFS_CUT, 32'hffff_ffff);
      power <= 16'h0400;
      hit(WAM_OFS_CUT, 32'h0, 2'b01, 4);
      power <= 16'h0401;
      weld <= 1'h1;
      run <= 1'h1;
      repeat (6) @(posedge clk);
      #1 chk("cutoff stop", 32'h1, {31'h0, stop});
      chk("cutoff abort", 32'h0, {31'h0, abort});
      @(posedge clk);
      power <= 16'h0;
      hit(WAM_OFS_CUT, 32'h1 << WAM_B_PCUT, 2'b00, 1);
      ain1 <= 16'h0801;
      hit(WAM_OFS_CUT, 32'h1 << WAM_B_A1CUT, 2'b01, 3);
      ain1 <= 16'h0;
      ain2 <= 16'h0801;
      hit(WAM_OFS_CUT, 32'h1 << WAM_B_A2CUT, 2'b01, 3);
      ain2 <= 16'h0;
      fcut(16'h4c90, 32'h1 << WAM_B_FLCUT);
      fcut(16'h4d70, 32'h1 << WAM_B_FHCUT);
      power <= 16'h03ff;
      hit(WAM_OFS_CUT, 32'h1 << WAM_B_ECUT, 2'b01, 1100);
      power <= 16'h0;
      hit(WAM_OFS_CUT, 32'h1 << WAM_B_TCUT, 2'b01, 8200);
      $display("test cutoff done");
   endtask
   task t_temp_preset();
      temp <= WAM_TEMP_TRIP;
      repeat (2) @(posedge clk);
      rd("temperature", WAM_OFS_OVL, 32'h1 << WAM_B_TEMP);
      apb(1'h1, WAM_OFS_OVL, 32'hffff_ffff);
      rd("temperature", WAM_OFS_OVL, 32'h1 << WAM_B_TEMP);
      temp <= WAM_TEMP_TRIP - 8'h01;
      @(posedge clk);
      apb(1'h1, WAM_OFS_OVL, 32'hffff_ffff);
      rd("temperature", WAM_OFS_OVL, 32'h0);
      for (int i = 0; i < 2; i++)
      begin
         preq <= 1'h1;
         pnum <= WAM_PRESET_MAX + 8'(i);
         @(posedge clk);
         preq <= 1'h0;
         @(posedge clk);
         rd("setup", WAM_OFS_SET, 32'(i) << WAM_B_PRESET);
      end
      $display("test temperature and preset done");
   endtask
   initial
   begin
      do_reset(1'h0);
      t_cold();
      t_overload();
      t_cutoff();
      t_temp_preset();
      stop_test();
   end
endmodule
